// File: logic/slow_mode_defines.svh
`ifndef SLOW_MODE_DEFINES_SVH
`define SLOW_MODE_DEFINES_SVH
// ****************************************
// Register offsets (word addresses)
// ****************************************
`define OFS_SYSCTL 4'h0
`define OFS_LTCTL 4'h1
`define OFS_UTCTL 4'h2
`define OFS_LTCMP 4'h3
`define OFS_UTCMP 4'h4
`define OFS_IRQ 4'h5
`define OFS_STATUS 4'h6
// ****************************************
// Field positions and reset values
// ****************************************
`define BIT_HF_EN 7
`define BIT_LF_EN 6
`define BIT_CLK_SEL 5
`define BIT_WDT_EN 0
`define BIT_SRC_HF 5
`define BIT_TMR_RUN 3
`define LT_CASCADE 2'h3
`define UT_WARMUP 3'h5
`define SYSCTL_RST 8'h81
`define IRQ_MASTER 0
`define IRQ_SRC_EN 1
`define IRQ_LATCH 2
`define RESET_VECTOR 16'hfffe
// ****************************************
// Timing
// ****************************************
`define CLK_NS 100
`define EXT_RST_NS (12 * `CLK_NS)
`define EXT_RST_CYC ((`EXT_RST_NS + `CLK_NS - 1) / `CLK_NS)
`define MAL_RST_NS (24 * `CLK_NS)
`define MAL_RST_CYC (`MAL_RST_NS / `CLK_NS)
`endif

// File: logic/slow_mode_pkg.sv
package slow_mode_pkg;
  typedef enum logic [1:0] {
    fast_single_clock_mode,
    fast_dual_clock_mode,
    slow_dual_osc_mode,
    slow_single_osc_mode
  } op_mode_t;
  typedef enum logic [1:0] {rst_run, rst_ext, rst_mal} rst_state_t;
endpackage

// File: logic/slow_mode_switch_and_reset.sv
`timescale 1ns/10ps
`default_nettype none
`include "slow_mode_defines.svh"
module slow_mode_switch_and_reset
  import slow_mode_pkg::*;
#(
  parameter int LOW_DIV = 305
) (
  input wire logic clk_i, // 10 MHz, also the high clock
  input wire logic rst_n_i, // Power-on reset
  input wire logic [3:0] address_i, // Avalon word address
  input wire logic read_i, // Avalon read
  input wire logic write_i, // Avalon write
  input wire logic [3:0] byteenable_i, // Avalon byte enables
  input wire logic [31:0] writedata_i, // Avalon write data
  output logic [31:0] readdata_o, // Avalon read data
  output logic waitrequest_o, // Avalon wait
  input wire logic reset_pin_i, // Reset pin level
  output logic reset_pin_o, // Reset pin drive value
  output logic reset_pin_oe_n_o, // Low while pin driven
  input wire logic addr_trap_i, // Address trap request
  input wire logic wdt_reset_i, // Watchdog reset request
  output logic core_reset_o, // Internal reset to core
  output logic pc_load_o, // Load vector into program counter
  output logic [15:0] vector_addr_o, // Vector address
  output logic hf_osc_en_o, // High oscillator enable
  output logic lf_osc_en_o, // Low oscillator enable
  output logic clk_is_low_o, // Core runs on low clock
  output logic wdt_en_o, // Watchdog enable
  output logic warmup_done_irq_o // Warm-up interrupt request
);
  initial begin
    if (LOW_DIV < 2 || LOW_DIV > 65535) begin
      $error("LOW_DIV out of range");
    end
  end

  logic [7:0] system_control_two;
  logic [7:0] lower_timer_control;
  logic [7:0] upper_timer_control;
  logic [7:0] lower_timer_compare;
  logic [7:0] upper_timer_compare;
  logic irq_master_enable, irq_source_enable, irq_request_latch;
  logic [15:0] prescaler, warm_cnt;
  logic low_tick, ack, soft_rst, clk_fault, warm_hit, timer_on;
  logic s1, s2, s3, pin_lvl;
  logic [4:0] ext_cnt, mal_cnt;
  logic [1:0] last_cause;
  rst_state_t rst_state;
  op_mode_t mode;

  function automatic logic hit(input logic [3:0] ofs);
    hit = write_i && ack && address_i == ofs && byteenable_i[0];
  endfunction

  // ****************************************
  // Avalon slave: one wait state per access
  // ****************************************
  assign waitrequest_o = (read_i || write_i) && !ack;

  // Ack flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack <= 1'b0;
    end else begin
      ack <= (read_i || write_i) && !ack;
    end
  end

  // Read mux, unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readdata_o <= 32'h0;
    end else if (read_i && !ack) begin
      case (address_i)
        `OFS_SYSCTL: readdata_o <= {24'h0, system_control_two};
        `OFS_LTCTL: readdata_o <= {24'h0, lower_timer_control};
        `OFS_UTCTL: readdata_o <= {24'h0, upper_timer_control};
        `OFS_LTCMP: readdata_o <= {24'h0, lower_timer_compare};
        `OFS_UTCMP: readdata_o <= {24'h0, upper_timer_compare};
        `OFS_IRQ: readdata_o <= {29'h0, irq_request_latch, irq_source_enable,
                                 irq_master_enable};
        `OFS_STATUS: readdata_o <= {24'h0, last_cause, 1'b0,
                                    system_control_two[`BIT_CLK_SEL] != clk_is_low_o,
                                    clk_is_low_o, 1'b0, mode};
        default: readdata_o <= 32'h0;
      endcase
    end
  end

  // ****************************************
  // Clock control
  // ****************************************
  // Fault check uses the select bit in force before the write
  always_comb begin
    clk_fault = 1'b0;
    if (hit(`OFS_SYSCTL)) begin
      clk_fault = (!writedata_i[`BIT_HF_EN] && !writedata_i[`BIT_LF_EN]
                   && (hf_osc_en_o || lf_osc_en_o))
        || (hf_osc_en_o && !writedata_i[`BIT_HF_EN]
            && !system_control_two[`BIT_CLK_SEL])
        || (lf_osc_en_o && !writedata_i[`BIT_LF_EN]
            && system_control_two[`BIT_CLK_SEL]);
    end
  end

  // Faulting write is dropped; the malfunction reset then reloads SYSCTL_RST
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      system_control_two <= `SYSCTL_RST;
    end else if (soft_rst) begin
      system_control_two <= `SYSCTL_RST;
    end else if (hit(`OFS_SYSCTL) && !clk_fault) begin
      system_control_two <= writedata_i[7:0];
    end
  end
  assign hf_osc_en_o = system_control_two[`BIT_HF_EN];
  assign lf_osc_en_o = system_control_two[`BIT_LF_EN];
  assign wdt_en_o = system_control_two[`BIT_WDT_EN];

  // Prescaler gives the low clock tick; cleared by any reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prescaler <= 16'h0;
    end else if (soft_rst || prescaler == 16'(LOW_DIV - 1)) begin
      prescaler <= 16'h0;
    end else begin
      prescaler <= prescaler + 16'h1;
    end
  end
  assign low_tick = lf_osc_en_o && prescaler == 16'(LOW_DIV - 1);

  // Switch only on a low clock edge so the two clocks stay aligned
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clk_is_low_o <= 1'b0;
    end else if (soft_rst) begin
      clk_is_low_o <= 1'b0;
    end else if (low_tick) begin
      clk_is_low_o <= system_control_two[`BIT_CLK_SEL];
    end
  end

  // Mode as seen by software
  always_comb begin
    if (system_control_two[`BIT_CLK_SEL]) begin
      mode = hf_osc_en_o ? slow_dual_osc_mode : slow_single_osc_mode;
    end else begin
      mode = lf_osc_en_o ? fast_dual_clock_mode : fast_single_clock_mode;
    end
  end

  // ****************************************
  // Warm-up timer pair
  // ****************************************
  // Timer control and compare registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lower_timer_control <= 8'h0;
      upper_timer_control <= 8'h0;
      lower_timer_compare <= 8'h0;
      upper_timer_compare <= 8'h0;
    end else if (soft_rst) begin
      lower_timer_control <= 8'h0;
      upper_timer_control <= 8'h0;
      lower_timer_compare <= 8'h0;
      upper_timer_compare <= 8'h0;
    end else begin
      if (hit(`OFS_LTCTL)) lower_timer_control <= writedata_i[7:0];
      if (hit(`OFS_UTCTL)) upper_timer_control <= writedata_i[7:0];
      if (hit(`OFS_LTCMP)) lower_timer_compare <= writedata_i[7:0];
      if (hit(`OFS_UTCMP)) upper_timer_compare <= writedata_i[7:0];
    end
  end

  assign timer_on = upper_timer_control[`BIT_TMR_RUN]
    && upper_timer_control[2:0] == `UT_WARMUP
    && lower_timer_control[1:0] == `LT_CASCADE;
  assign warm_hit = timer_on && warm_cnt == {upper_timer_compare, lower_timer_compare};

  // Counter runs off the chosen source and halts on the match
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warm_cnt <= 16'h0;
    end else if (soft_rst || !timer_on) begin
      warm_cnt <= 16'h0;
    end else if (!warm_hit && (lower_timer_control[`BIT_SRC_HF]
                               ? hf_osc_en_o : low_tick)) begin
      warm_cnt <= warm_cnt + 16'h1;
    end
  end

  // Interrupt flags; a match beats a software clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_master_enable <= 1'b0;
      irq_source_enable <= 1'b0;
      irq_request_latch <= 1'b0;
    end else if (soft_rst) begin
      irq_master_enable <= 1'b0;
      irq_source_enable <= 1'b0;
      irq_request_latch <= 1'b0;
    end else begin
      if (hit(`OFS_IRQ)) begin
        irq_master_enable <= writedata_i[`IRQ_MASTER];
        irq_source_enable <= writedata_i[`IRQ_SRC_EN];
      end
      if (warm_hit) begin
        irq_request_latch <= 1'b1;
      end else if (hit(`OFS_IRQ) && !writedata_i[`IRQ_LATCH]) begin
        irq_request_latch <= 1'b0;
      end
    end
  end
  assign warmup_done_irq_o = irq_request_latch && irq_source_enable && irq_master_enable;

  // ****************************************
  // Reset generator
  // ****************************************
  // Three-stage pin sampler; level changes when stages two and three agree
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      pin_lvl <= 1'b1;
    end else begin
      s1 <= reset_pin_i;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) pin_lvl <= s3;
    end
  end

  // Low-time counter; own drive is masked so it cannot re-trigger itself
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ext_cnt <= 5'h0;
    end else if (pin_lvl || rst_state == rst_mal) begin
      ext_cnt <= 5'h0;
    end else if (ext_cnt < 5'(`EXT_RST_CYC)) begin
      ext_cnt <= ext_cnt + 5'h1;
    end
  end

  // Power-up starts in a malfunction pulse, since that logic has no init
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_state <= rst_mal;
      mal_cnt <= 5'(`MAL_RST_CYC - 1);
      last_cause <= 2'h0;
    end else begin
      case (rst_state)
        rst_run: begin
          if (addr_trap_i || wdt_reset_i || clk_fault) begin
            rst_state <= rst_mal;
            mal_cnt <= 5'(`MAL_RST_CYC - 1);
            last_cause <= addr_trap_i ? 2'h1 : (wdt_reset_i ? 2'h2 : 2'h3);
          end else if (ext_cnt == 5'(`EXT_RST_CYC)) begin
            rst_state <= rst_ext;
            last_cause <= 2'h0;
          end
        end
        rst_ext: begin
          if (pin_lvl) rst_state <= rst_run;
        end
        rst_mal: begin
          if (mal_cnt == 5'h0) begin
            rst_state <= rst_run;
          end else begin
            mal_cnt <= mal_cnt - 5'h1;
          end
        end
        default: rst_state <= rst_run;
      endcase
    end
  end
  assign soft_rst = rst_state != rst_run;
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe_n_o = rst_state != rst_mal;

  // Core reset and vector load on release
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      core_reset_o <= 1'b1;
      pc_load_o <= 1'b0;
      vector_addr_o <= `RESET_VECTOR;
    end else begin
      core_reset_o <= soft_rst;
      pc_load_o <= core_reset_o && !soft_rst;
      vector_addr_o <= `RESET_VECTOR;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_mal_len;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_state == rst_mal) |-> (rst_state == rst_mal) [*8] ##17 rst_state != rst_mal;
  endproperty
  a_mal_len: assert property (p_mal_len) else $error("malfunction length wrong");

  property p_pin_drive;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rst_state == rst_mal) |-> !reset_pin_oe_n_o && !reset_pin_o && soft_rst;
  endproperty
  a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");

  property p_fault;
    @(posedge clk_i) disable iff (!rst_n_i)
    (clk_fault && rst_state == rst_run) |=> rst_state == rst_mal ##1 !reset_pin_oe_n_o;
  endproperty
  a_fault: assert property (p_fault) else $error("clock fault missed");

  property p_release_state;
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(core_reset_o) |-> pc_load_o && vector_addr_o == `RESET_VECTOR
      && !irq_master_enable && !irq_source_enable && wdt_en_o
      && mode == fast_single_clock_mode && !clk_is_low_o;
  endproperty
  a_release_state: assert property (p_release_state) else $error("bad release state");

  property p_clk_hold;
    @(posedge clk_i) disable iff (!rst_n_i)
    (clk_is_low_o && !system_control_two[`BIT_CLK_SEL] && !low_tick && !soft_rst)
      |=> clk_is_low_o;
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("switched off edge");

  property p_warm_irq;
    @(posedge clk_i) disable iff (!rst_n_i)
    (warm_hit && !soft_rst) |=> irq_request_latch;
  endproperty
  a_warm_irq: assert property (p_warm_irq) else $error("warm-up latch lost");

  property p_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
    system_control_two[`BIT_CLK_SEL] |-> (mode == slow_dual_osc_mode) == hf_osc_en_o;
  endproperty
  a_mode: assert property (p_mode) else $error("mode report wrong");

  property p_ext_apply;
    @(posedge clk_i) disable iff (!rst_n_i)
    (rst_state == rst_run && $fell(pin_lvl)) |-> ##[1:13] soft_rst || pin_lvl;
  endproperty
  a_ext_apply: assert property (p_ext_apply) else $error("pin reset late");

  property p_wait;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(read_i) |-> waitrequest_o ##1 !waitrequest_o;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");

  c_slow_single: cover property (@(posedge clk_i) mode == slow_single_osc_mode);
  c_ext: cover property (@(posedge clk_i) rst_state == rst_ext);
  c_irq: cover property (@(posedge clk_i) warmup_done_irq_o);
  c_back: cover property (@(posedge clk_i) $fell(clk_is_low_o) && !soft_rst);
endmodule
`default_nettype wire

// File: verif/sw_master.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Software side of the register bus
// ****************************************
module sw_master (
  input wire logic clk_i, // Bus clock
  input wire logic [31:0] readdata_i, // Read data
  input wire logic waitrequest_i, // Slave stall
  output logic [3:0] address_o, // Word address
  output logic read_o, // Read strobe
  output logic write_o, // Write strobe
  output logic [3:0] byteenable_o, // Byte lanes
  output logic [31:0] writedata_o // Write data
);
  // Idle bus at time zero
  initial begin
    address_o = 4'h0;
    read_o = 1'b0;
    write_o = 1'b0;
    byteenable_o = 4'h1;
    writedata_o = 32'h0;
  end
  // Request held until a rising edge sees waitrequest low
  task automatic access(input logic wr, input logic [3:0] a, input logic [7:0] d,
                        output logic [31:0] q);
    @(posedge clk_i);
    address_o <= a;
    writedata_o <= {24'h0, d};
    write_o <= wr;
    read_o <= ~wr;
    @(posedge clk_i);
    while (waitrequest_i !== 1'b0) @(posedge clk_i);
    q = readdata_i;
    write_o <= 1'b0;
    read_o <= 1'b0;
    writedata_o <= ~writedata_o; // Stale data would hide a missed write
  endtask
  // Cascaded warm-up count, started with its interrupt enabled
  task automatic warm_up(input logic [7:0] src, input logic [7:0] lo);
    logic [31:0] q;
    access(1'b1, 4'h1, src, q);
    access(1'b1, 4'h2, 8'h05, q);
    access(1'b1, 4'h3, lo, q);
    access(1'b1, 4'h4, 8'h00, q);
    access(1'b1, 4'h5, 8'h03, q);
    access(1'b1, 4'h2, 8'h0d, q);
  endtask
  // Handler: stop the timers and drop the request
  task automatic warm_ack();
    logic [31:0] q;
    access(1'b1, 4'h2, 8'h05, q);
    access(1'b1, 4'h5, 8'h03, q);
  endtask
endmodule
`default_nettype wire

// File: verif/slow_mode_switch_and_reset_tb.sv
`timescale 1ns/10ps
`default_nettype none
module slow_mode_switch_and_reset_tb;
  import slow_mode_pkg::*;
  localparam int LOW_DIV = 4;
  logic clk_i;
  logic rst_n_i;
  logic addr_trap_i;
  logic wdt_reset_i;
  logic ext_low;
  logic reset_pin_i;
  logic [3:0] address_i;
  logic read_i;
  logic write_i;
  logic [3:0] byteenable_i;
  logic [31:0] writedata_i;
  logic [31:0] readdata_o;
  logic waitrequest_o;
  logic reset_pin_o;
  logic reset_pin_oe_n_o;
  logic core_reset_o;
  logic pc_load_o;
  logic [15:0] vector_addr_o;
  logic hf_osc_en_o;
  logic lf_osc_en_o;
  logic clk_is_low_o;
  logic wdt_en_o;
  logic warmup_done_irq_o;
  int fail_count;
  int n_checks;
  // Pulled-up pin: low if the board or the device pulls it
  assign reset_pin_i = ext_low ? 1'b0 : (reset_pin_oe_n_o ? 1'b1 : reset_pin_o);
  slow_mode_switch_and_reset #(.LOW_DIV(LOW_DIV)) slow_mode_switch_and_reset_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_n_o(reset_pin_oe_n_o),
    .addr_trap_i(addr_trap_i), .wdt_reset_i(wdt_reset_i), .core_reset_o(core_reset_o),
    .pc_load_o(pc_load_o), .vector_addr_o(vector_addr_o), .hf_osc_en_o(hf_osc_en_o),
    .lf_osc_en_o(lf_osc_en_o), .clk_is_low_o(clk_is_low_o), .wdt_en_o(wdt_en_o),
    .warmup_done_irq_o(warmup_done_irq_o));
  sw_master sw_master_inst (
    .clk_i(clk_i), .readdata_i(readdata_o), .waitrequest_i(waitrequest_o),
    .address_o(address_i), .read_o(read_i), .write_o(write_i),
    .byteenable_o(byteenable_i), .writedata_o(writedata_i));
  // ****************************************
  // Helpers
  // ****************************************
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic check1(input string name, input logic seen, input logic exp);
    check(name, {31'h0, seen}, {31'h0, exp});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] q);
    sw_master_inst.access(1'b0, a, 8'h00, q);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [31:0] q;
    sw_master_inst.access(1'b1, a, d, q);
  endtask
  // Bounded wait on the warm-up request (0) or the clock source flag (1)
  task automatic wait_for(input int which, input logic v, input int lim, output int n);
    n = 0;
    while (((which == 0) ? warmup_done_irq_o : clk_is_low_o) !== v && n < lim) begin
      @(negedge clk_i);
      n++;
    end
  endtask
  // Cycles during which the device itself pulls the pin low
  task automatic count_oe(output int n);
    int k;
    n = 0;
    k = 0;
    while (reset_pin_oe_n_o !== 1'b0 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    while (reset_pin_oe_n_o === 1'b0 && n < 100) begin
      n++;
      @(negedge clk_i);
      if (n == 2) check1("core_reset_o held", core_reset_o, 1'b1);
      if (n == 2) check1("reset_pin_o", reset_pin_o, 1'b0);
    end
  endtask
  // Reset release: vector load pulse, then registers at reset values
  task automatic wait_boot();
    logic [31:0] q;
    int k;
    k = 0;
    while (pc_load_o !== 1'b1 && k < 60) begin
      @(negedge clk_i);
      k++;
    end
    check1("pc_load_o", pc_load_o, 1'b1);
    check("vector_addr_o", {16'h0, vector_addr_o}, 32'hfffe);
    check1("core_reset_o", core_reset_o, 1'b0);
    @(negedge clk_i);
    check1("pc_load_o pulse", pc_load_o, 1'b0);
    rd(4'h0, q);
    check("system_control_two", q, 32'h81);
    rd(4'h5, q);
    check("irq flags", q & 32'h7, 32'h0);
    rd(4'h6, q);
    check("mode", q & 32'h7, 32'(fast_single_clock_mode));
    check1("wdt_en_o", wdt_en_o, 1'b1);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_bus();
    logic [31:0] q;
    wr(4'h7, 8'hff);
    rd(4'h7, q);
    check("unmapped", q, 32'h0);
  endtask
  // Fast dual to slow single, low oscillator warmed up first
  task automatic t_slow();
    logic [31:0] q;
    int n;
    wr(4'h0, 8'hc0);
    sw_master_inst.warm_up(8'h03, 8'h08);
    check1("irq early", warmup_done_irq_o, 1'b0);
    wait_for(0, 1'b1, 400, n);
    check1("low warm-up span", n >= 24 && n <= 40, 1'b1);
    sw_master_inst.warm_ack();
    wr(4'h0, 8'he0);
    wait_for(1, 1'b1, 20, n);
    rd(4'h6, q);
    check("slow dual", q & 32'hf, 32'ha);
    check1("hf kept", hf_osc_en_o, 1'b1);
    wr(4'h0, 8'h60);
    rd(4'h6, q);
    check("slow single", q & 32'hf, 32'hb);
    check1("lf on", lf_osc_en_o, 1'b1);
  endtask
  // Slow single back to fast dual on the high-clock warm-up
  task automatic t_return();
    logic [31:0] q;
    int n;
    wr(4'h0, 8'he0);
    sw_master_inst.warm_up(8'h23, 8'h10);
    wait_for(0, 1'b1, 400, n);
    check1("high warm-up span", n >= 12 && n <= 20, 1'b1);
    sw_master_inst.warm_ack();
    wr(4'h0, 8'hc0);
    wait_for(1, 1'b0, 2 * LOW_DIV + 4, n);
    rd(4'h6, q);
    check("fast dual", q & 32'hf, 32'h1);
  endtask
  // Trap, watchdog and the three clock faults, one after another
  task automatic t_mal();
    logic [31:0] q;
    int n;
    for (int i = 0; i < 5; i++) begin
      wr(4'h0, (i == 4) ? 8'he0 : 8'hc0);
      if (i < 2) begin
        addr_trap_i <= (i == 0);
        wdt_reset_i <= (i == 1);
        @(posedge clk_i);
        addr_trap_i <= 1'b0;
        wdt_reset_i <= 1'b0;
      end else begin
        wr(4'h0, (i == 3) ? 8'h40 : ((i == 4) ? 8'ha0 : 8'h00));
      end
      count_oe(n);
      check("malfunction span", n, 24);
      wait_boot();
      rd(4'h6, q);
      check("cause", (q >> 6) & 32'h3, (i < 2) ? i + 1 : 3);
    end
  endtask
  // Short pin pulse ignored; long one leaves slow mode
  task automatic t_ext();
    int n;
    wr(4'h0, 8'hc0);
    wr(4'h0, 8'he0);
    wr(4'h5, 8'h03);
    wait_for(1, 1'b1, 20, n);
    ext_low <= 1'b1;
    repeat (5) @(posedge clk_i);
    ext_low <= 1'b0;
    repeat (20) @(posedge clk_i);
    check1("short pulse", core_reset_o, 1'b0);
    ext_low <= 1'b1;
    repeat (20) @(posedge clk_i);
    check1("pin reset", core_reset_o, 1'b1);
    check1("pin left alone", reset_pin_oe_n_o, 1'b1);
    ext_low <= 1'b0;
    wait_boot();
  endtask
  // Clock, 100 ns period
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // Whole run is well under 1000 cycles; reaching the 6000-cycle limit means a hang
  initial begin
    repeat (6000) @(posedge clk_i);
    fail_count++;
    close_out();
  end
  // Main sequence
  initial begin
    int n;
    fail_count = 0;
    n_checks = 0;
    rst_n_i = 1'b0;
    addr_trap_i = 1'b0;
    wdt_reset_i = 1'b0;
    ext_low = 1'b0;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    count_oe(n);
    check("power-up pulse", n, 24);
    wait_boot();
    t_bus();
    t_slow();
    t_return();
    t_mal();
    t_ext();
    close_out();
  end
endmodule
`default_nettype wire
